// [common/imu_seq_pkg.sv]
// Constants for the command sequencing and sync timing block.
// Assumes a single 50 MHz system clock.
package imu_seq_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  // Nominal durations, in ms and us, and the full SPI load in words
  localparam int unsigned STARTUP_MS = 310;
  localparam int unsigned RESET_REC_MS = 255;
  localparam int unsigned CAL_RESTORE_MS = 136;
  localparam int unsigned FLASH_BACKUP_MS = 70;
  localparam int unsigned FLASH_TEST_MS = 30;
  localparam int unsigned SELF_TEST_MS = 24;
  localparam int unsigned SYNC_DR_IDLE_US = 305;
  localparam int unsigned SYNC_DR_FULL_US = 405;
  localparam int unsigned FULL_LOAD_WORDS = 64;
  // Derived cycle counts
  localparam int unsigned MS_CYC = CLK_HZ / 1000;
  localparam int unsigned STARTUP_CYC = STARTUP_MS * MS_CYC;
  localparam int unsigned RESET_REC_CYC = RESET_REC_MS * MS_CYC;
  localparam int unsigned CAL_RESTORE_CYC = CAL_RESTORE_MS * MS_CYC;
  localparam int unsigned FLASH_BACKUP_CYC = FLASH_BACKUP_MS * MS_CYC;
  localparam int unsigned FLASH_TEST_CYC = FLASH_TEST_MS * MS_CYC;
  localparam int unsigned SELF_TEST_CYC = SELF_TEST_MS * MS_CYC;
  localparam int unsigned SYNC_DR_IDLE_CYC = SYNC_DR_IDLE_US * CLK_MHZ;
  localparam int unsigned SYNC_DR_FULL_CYC = SYNC_DR_FULL_US * CLK_MHZ;
  // Extra cycles per word read of the previous sample
  localparam int unsigned WORD_EXTRA_CYC =
    (SYNC_DR_FULL_CYC - SYNC_DR_IDLE_CYC) / FULL_LOAD_WORDS;
  // Self test stretch factor when sample clock is slow
  localparam int unsigned SELF_TEST_SLOW_NUM = 2;
  // Global command bit positions
  localparam int unsigned CMD_RESET_BIT = 7;
  localparam int unsigned CMD_CAL_BIT = 1;
  localparam int unsigned CMD_BACKUP_BIT = 3;
  localparam int unsigned CMD_FTEST_BIT = 4;
  localparam int unsigned CMD_STEST_BIT = 2;
  // Sync mode field value for direct sync
  localparam logic [1:0] SYNC_DIRECT = 2'h1;
  localparam int unsigned CNT_W = 25;
  localparam int unsigned WORD_CNT_W = 8;
  typedef enum logic [3:0] {
    ST_BOOT = 4'h1,
    ST_RUN  = 4'h2,
    ST_BUSY = 4'h4,
    ST_WAIT = 4'h8
  } seq_state_t;
endpackage : imu_seq_pkg

// [design/imu_cmd_seq.sv]
// Command sequencing and direct-sync data-ready timing of the sensor.
// Assumes CLK_SYS at 50 MHz; sync and word strobes come from pins.
// Operation
// - No valid data until the 310 ms startup interval has passed.
// - Command bit 7 resets; data returns after 255 ms.
// - Command bit 1 restores calibration, done in 136 ms.
// - Command bit 3 backs up settings to flash, done in 70 ms.
// - Command bit 4 tests flash, done in 30 ms.
// - Command bit 2 runs self test, done in 24 ms.
// - A slow external sample clock may lengthen the self test.
// - Idle direct sync gives data ready 305 us after the edge.
// - Full SPI load stretches that delay to 405 us.
// - The delay grows with words read of the previous sample.
`timescale 1ns/1ns
module imu_cmd_seq
  import imu_seq_pkg::*;
#(
  parameter int unsigned STARTUP_C   = STARTUP_CYC,
  parameter int unsigned RESET_C     = RESET_REC_CYC,
  parameter int unsigned CAL_C       = CAL_RESTORE_CYC,
  parameter int unsigned BACKUP_C    = FLASH_BACKUP_CYC,
  parameter int unsigned FTEST_C     = FLASH_TEST_CYC,
  parameter int unsigned STEST_C     = SELF_TEST_CYC,
  parameter int unsigned SYNC_IDLE_C = SYNC_DR_IDLE_CYC,
  parameter int unsigned WORD_C      = WORD_EXTRA_CYC
) (
  input  wire logic       CLK_SYS,
  input  wire logic       SRST,
  input  wire logic [7:0] GLOBAL_CMD,
  input  wire logic       GLOBAL_CMD_WR,
  input  wire logic [1:0] SYNC_MODE,
  input  wire logic       SLOW_CLK,
  input  wire logic       SYNC_IN,
  input  wire logic       WORD_DONE,
  output logic            DATA_READY,
  output logic            DATA_VALID,
  output logic            BUSY
);
  import imu_seq_pkg::*;

  logic sync_rise, word_rise;

  imu_sync_in u_sync (
    .clk   (CLK_SYS),
    .srst  (SRST),
    .din   (SYNC_IN),
    .level (),
    .rise  (sync_rise)
  );

  imu_sync_in u_word (
    .clk   (CLK_SYS),
    .srst  (SRST),
    .din   (WORD_DONE),
    .level (),
    .rise  (word_rise)
  );

  seq_state_t            st_q, st_d;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic                  valid_q, valid_d;
  logic                  busy_q, busy_d;
  logic                  wait_q, wait_d;
  logic [CNT_W-1:0]      dly_q, dly_d;
  logic [WORD_CNT_W-1:0] words_q, words_d;
  logic                  dr_q, dr_d;
  logic                  direct;
  logic [CNT_W-1:0]      cmd_len;
  logic                  cmd_hit;

  assign direct = (SYNC_MODE == SYNC_DIRECT);

  // Priority: reset beats every other command bit
  always_comb begin
    cmd_hit = 1'b1;
    if (GLOBAL_CMD[CMD_RESET_BIT])
      cmd_len = CNT_W'(RESET_C);
    else if (GLOBAL_CMD[CMD_CAL_BIT])
      cmd_len = CNT_W'(CAL_C);
    else if (GLOBAL_CMD[CMD_BACKUP_BIT])
      cmd_len = CNT_W'(BACKUP_C);
    else if (GLOBAL_CMD[CMD_FTEST_BIT])
      cmd_len = CNT_W'(FTEST_C);
    else if (GLOBAL_CMD[CMD_STEST_BIT])
      // Slow sample clock doubles the self test
      cmd_len = SLOW_CLK ? CNT_W'(STEST_C * SELF_TEST_SLOW_NUM)
                         : CNT_W'(STEST_C);
    else begin
      cmd_len = '0;
      cmd_hit = 1'b0;
    end
  end

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    valid_d = valid_q;
    busy_d  = busy_q;
    unique case (st_q)
      ST_BOOT: begin
        if (cnt_q == CNT_W'(STARTUP_C - 1)) begin
          st_d    = ST_RUN;
          valid_d = 1'b1;
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_RUN: begin
        if (GLOBAL_CMD_WR && cmd_hit) begin
          st_d    = ST_BUSY;
          cnt_d   = cmd_len - 1'b1;
          valid_d = 1'b0;
          busy_d  = 1'b1;
        end
      end
      ST_BUSY: begin
        // Writes during a command are ignored, no queueing
        if (cnt_q == '0) begin
          st_d    = ST_RUN;
          valid_d = 1'b1;
          busy_d  = 1'b0;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        st_d    = ST_BOOT;
        cnt_d   = '0;
        valid_d = 1'b0;
        busy_d  = 1'b0;
      end
    endcase
  end

  // Sync edge to data ready, stretched by reads of the prior sample
  always_comb begin
    wait_d  = wait_q;
    dly_d   = dly_q;
    words_d = words_q;
    dr_d    = 1'b0;
    if (word_rise && words_q != '1)
      words_d = words_q + 1'b1;
    if (wait_q) begin
      if (dly_q == '0) begin
        wait_d = 1'b0;
        dr_d   = valid_q & ~busy_q;
      end else begin
        dly_d = dly_q - 1'b1;
      end
    end
    if (sync_rise && direct && !wait_q) begin
      wait_d  = 1'b1;
      dly_d   = CNT_W'(SYNC_IDLE_C - 1)
                + CNT_W'(words_q * WORD_C);
      // A word on the sync edge counts towards the new sample
      words_d = WORD_CNT_W'(word_rise);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st_q    <= ST_BOOT;
      cnt_q   <= '0;
      valid_q <= 1'b0;
      busy_q  <= 1'b0;
      wait_q  <= 1'b0;
      dly_q   <= '0;
      words_q <= '0;
      dr_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      valid_q <= valid_d;
      busy_q  <= busy_d;
      wait_q  <= wait_d;
      dly_q   <= dly_d;
      words_q <= words_d;
      dr_q    <= dr_d;
    end
  end

  assign DATA_READY = dr_q;
  assign DATA_VALID = valid_q;
  assign BUSY       = busy_q;

  // Helper: cycles since release of reset, saturating
  logic [CNT_W-1:0] up_q;
  always_ff @(posedge CLK_SYS) begin
    if (SRST)
      up_q <= '0;
    else if (up_q != '1)
      up_q <= up_q + 1'b1;
  end

  property p_no_valid_early;
    @(posedge CLK_SYS) disable iff (SRST)
      (up_q < CNT_W'(STARTUP_C)) |-> !DATA_VALID;
  endproperty
  a_no_valid_early: assert property (p_no_valid_early)
    else $error("data valid before startup");

  property p_boot_ends;
    @(posedge CLK_SYS) disable iff (SRST)
      (st_q == ST_BOOT && cnt_q == CNT_W'(STARTUP_C - 1)) |=> DATA_VALID;
  endproperty
  a_boot_ends: assert property (p_boot_ends)
    else $error("startup did not end");

  property p_reset_cmd;
    @(posedge CLK_SYS) disable iff (SRST)
      (st_q == ST_RUN && GLOBAL_CMD_WR && GLOBAL_CMD[CMD_RESET_BIT])
      |=> BUSY && cnt_q == CNT_W'(RESET_C - 1);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd)
    else $error("reset command length wrong");

  property p_cal_cmd;
    @(posedge CLK_SYS) disable iff (SRST)
      (st_q == ST_RUN && GLOBAL_CMD_WR && GLOBAL_CMD == 8'h02)
      |=> BUSY && cnt_q == CNT_W'(CAL_C - 1);
  endproperty
  a_cal_cmd: assert property (p_cal_cmd)
    else $error("calibration restore length wrong");

  property p_backup_cmd;
    @(posedge CLK_SYS) disable iff (SRST)
      (st_q == ST_RUN && GLOBAL_CMD_WR && GLOBAL_CMD == 8'h08)
      |=> cnt_q == CNT_W'(BACKUP_C - 1);
  endproperty
  a_backup_cmd: assert property (p_backup_cmd)
    else $error("flash backup length wrong");

  property p_ftest_cmd;
    @(posedge CLK_SYS) disable iff (SRST)
      (st_q == ST_RUN && GLOBAL_CMD_WR && GLOBAL_CMD == 8'h10)
      |=> cnt_q == CNT_W'(FTEST_C - 1);
  endproperty
  a_ftest_cmd: assert property (p_ftest_cmd)
    else $error("flash test length wrong");

  property p_stest_cmd;
    @(posedge CLK_SYS) disable iff (SRST)
      (st_q == ST_RUN && GLOBAL_CMD_WR && GLOBAL_CMD == 8'h04 && !SLOW_CLK)
      |=> cnt_q == CNT_W'(STEST_C - 1);
  endproperty
  a_stest_cmd: assert property (p_stest_cmd)
    else $error("self test length wrong");

  property p_busy_quiet;
    @(posedge CLK_SYS) disable iff (SRST)
      $past(busy_q) |-> !DATA_READY;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data ready while busy");

  property p_sync_delay;
    @(posedge CLK_SYS) disable iff (SRST)
      (sync_rise && direct && !wait_q && words_q == '0)
      |=> dly_q == CNT_W'(SYNC_IDLE_C - 1);
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("sync delay not loaded");

  property p_sync_stretch;
    @(posedge CLK_SYS) disable iff (SRST)
      (sync_rise && direct && !wait_q && words_q != '0)
      |=> dly_q > CNT_W'(SYNC_IDLE_C - 1);
  endproperty
  a_sync_stretch: assert property (p_sync_stretch)
    else $error("sync delay not stretched");

  c_ready: cover property (@(posedge CLK_SYS) disable iff (SRST)
    DATA_READY);
  c_cmd_done: cover property (@(posedge CLK_SYS) disable iff (SRST)
    $fell(BUSY));
  c_startup: cover property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(DATA_VALID));
endmodule : imu_cmd_seq

// [design/imu_sync_in.sv]
// Two-flop synchroniser with rising edge detect.
// Assumes input is asynchronous to CLK_SYS.
`timescale 1ns/1ns
module imu_sync_in (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      level,
  output logic      rise
);
  logic s1_q, s2_q, s3_q;
  logic s1_d, s2_d, s3_d;

  always_comb begin
    s1_d = din;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign level = s2_q;
  assign rise  = s2_q & ~s3_q;
endmodule : imu_sync_in

// [sim/imu_host_model.sv]
// Host model: sync pulses and SPI word strobes towards the sensor.
// Assumes the bench calls its tasks; edges are off the system clock.
`timescale 1ns/1ns
module imu_host_model (
  output logic SYNC_IN,
  output logic WORD_DONE
);
  initial begin
    SYNC_IN = 1'b0;
    WORD_DONE = 1'b0;
  end

  task automatic sync_pulse();
    SYNC_IN = 1'b1;
    #5000 SYNC_IN = 1'b0;
  endtask : sync_pulse

  // Strobe runs on a 160 ns link period; normal mode stalls per word
  task automatic read_words(input int n, input logic burst);
    repeat (n) begin
      #80 WORD_DONE = 1'b1;
      #80 WORD_DONE = 1'b0;
      if (!burst)
        #16000;
    end
  endtask : read_words
endmodule : imu_host_model

// [sim/tb_imu_cmd_seq.sv]
// Bench for the command sequencer, with shortened command times.
// Assumes the host model drives the sync and word pins.
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb_imu_cmd_seq;
  import imu_seq_pkg::*;
  localparam int ST_C = 200;
  localparam int RS_C = 150;
  localparam int CL_C = 120;
  localparam int BK_C = 90;
  localparam int FT_C = 60;
  localparam int SE_C = 40;
  localparam int SI_C = 100;
  localparam int WD_C = 5;
  // Wait limit, above the longest stretched sync delay
  localparam int DR_LIM = 600;
  // Mid-run reset lasts 10 us of system clock
  localparam int RST_HOLD = 500;
  logic       CLK_SYS, SRST, GLOBAL_CMD_WR, SLOW_CLK;
  logic       SYNC_IN, WORD_DONE, DATA_READY, DATA_VALID, BUSY;
  logic [7:0] GLOBAL_CMD;
  logic [1:0] SYNC_MODE;
  int         n_errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;

  imu_cmd_seq #(.STARTUP_C(ST_C), .RESET_C(RS_C), .CAL_C(CL_C),
    .BACKUP_C(BK_C), .FTEST_C(FT_C), .STEST_C(SE_C),
    .SYNC_IDLE_C(SI_C), .WORD_C(WD_C)) i_dut (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .GLOBAL_CMD(GLOBAL_CMD),
    .GLOBAL_CMD_WR(GLOBAL_CMD_WR), .SYNC_MODE(SYNC_MODE),
    .SLOW_CLK(SLOW_CLK), .SYNC_IN(SYNC_IN), .WORD_DONE(WORD_DONE),
    .DATA_READY(DATA_READY), .DATA_VALID(DATA_VALID), .BUSY(BUSY));
  imu_host_model host (.SYNC_IN(SYNC_IN), .WORD_DONE(WORD_DONE));

  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end

  // Durations are loose by a few cycles of synchroniser slack
  function automatic int near(input int m, input int e);
    return (m >= e - 3 && m <= e + 3) ? e : m;
  endfunction : near

  task automatic give_verdict();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      give_verdict();
    end
  end

  // Reset, then a write during boot that must be dropped
  task automatic do_reset(input int hold);
    int n;
    n = 0;
    @(negedge CLK_SYS);
    SRST = 1'b1;
    repeat (hold) @(negedge CLK_SYS);
    `CHK(DATA_VALID, 1'b0)
    SRST = 1'b0;
    while (DATA_VALID !== 1'b1 && n < 1000) begin
      @(negedge CLK_SYS);
      GLOBAL_CMD = 8'h04;
      GLOBAL_CMD_WR = (n == 20);
      n++;
    end
    `CHK(near(n, ST_C), ST_C)
    `CHK(BUSY, 1'b0)
  endtask : do_reset

  task automatic run_cmd(input logic [7:0] c, input logic slow,
                         input int exp, input logic again);
    int n;
    n = 2;
    @(negedge CLK_SYS);
    GLOBAL_CMD = c;
    SLOW_CLK = slow;
    GLOBAL_CMD_WR = 1'b1;
    @(negedge CLK_SYS);
    GLOBAL_CMD_WR = 1'b0;
    @(negedge CLK_SYS);
    `CHK(BUSY, logic'(exp != 0))
    `CHK(DATA_VALID, logic'(exp == 0))
    // A second write while busy must not restart the count
    while (BUSY === 1'b1 && n < 1000) begin
      @(negedge CLK_SYS);
      GLOBAL_CMD = 8'h80;
      GLOBAL_CMD_WR = again && (n == 10);
      n++;
    end
    `CHK(near(n, exp), exp)
    `CHK(DATA_VALID, 1'b1)
    SLOW_CLK = 1'b0;
  endtask : run_cmd

  task automatic sync_dr(input int words, input logic burst,
                         input logic dr);
    int n;
    int e;
    n = 0;
    e = dr ? SI_C + 4 + words * WD_C : DR_LIM;
    host.read_words(words, burst);
    @(negedge CLK_SYS);
    fork
      host.sync_pulse();
    join_none
    while (DATA_READY !== 1'b1 && n < DR_LIM) begin
      @(negedge CLK_SYS);
      n++;
    end
    `CHK(near(n, e), e)
    #6000;
  endtask : sync_dr

  initial begin
    SRST = 1'b1;
    GLOBAL_CMD = 8'h00;
    GLOBAL_CMD_WR = 1'b0;
    SYNC_MODE = SYNC_DIRECT;
    SLOW_CLK = 1'b0;
    do_reset(16);
    run_cmd(8'h82, 1'b0, RS_C, 1'b0);
    run_cmd(8'h02, 1'b0, CL_C, 1'b1);
    run_cmd(8'h08, 1'b0, BK_C, 1'b0);
    run_cmd(8'h10, 1'b0, FT_C, 1'b1);
    run_cmd(8'h04, 1'b0, SE_C, 1'b0);
    run_cmd(8'h04, 1'b1, SELF_TEST_SLOW_NUM * SE_C, 1'b0);
    run_cmd(8'h01, 1'b0, 0, 1'b0);
    sync_dr(0, 1'b0, 1'b1);
    sync_dr(4, 1'b0, 1'b1);
    sync_dr(8, 1'b0, 1'b1);
    // Full load in burst reads, which need no stall
    sync_dr(FULL_LOAD_WORDS, 1'b1, 1'b1);
    // Sync edges outside direct sync mode start nothing
    SYNC_MODE = 2'h0;
    sync_dr(0, 1'b0, 1'b0);
    SYNC_MODE = SYNC_DIRECT;
    fork
      run_cmd(8'h02, 1'b0, CL_C, 1'b0);
      sync_dr(0, 1'b0, 1'b0);
    join
    do_reset(RST_HOLD);
    sync_dr(0, 1'b0, 1'b1);
    give_verdict();
  end
endmodule : tb_imu_cmd_seq
